// File: core/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
   // ****************************************
   // mode field encodings
   // ****************************************
   typedef enum logic [1:0] {
      MODE_IDLE = 2'h0,
      MODE_AVD = 2'h1,
      MODE_ADO = 2'h2,
      MODE_PDN = 2'h3
   } pmc_mode_t;

   // ****************************************
   // clock power extension field layout
   // ****************************************
   localparam int CPE_PDEN_BIT = 5;
   localparam int CPE_FSEL_LSB = 0;
   localparam int CPE_FSEL_W = 4;

   // ****************************************
   // divider ratios of the crystal clock
   // ****************************************
   // periods in mclk cycles; mclk runs at twice the crystal rate
   localparam logic [3:0] DIV_12M288 = 4'h2;
   localparam logic [3:0] DIV_6M144 = 4'h4;
   localparam logic [3:0] DIV_4M096 = 4'h6;
   localparam logic [3:0] DIV_3M072 = 4'h8;
   localparam logic [7:0] DIV_1M536 = 8'h10;
   localparam logic [7:0] DIV_0M768 = 8'h20;
   localparam logic [7:0] DIV_0M384 = 8'h40;

   // ****************************************
   // timing
   // ****************************************
   localparam int XTAL_KHZ = 12288;
   localparam int FRAME_US = 125;
   localparam int MCLK_PER_XTAL = 2;
   localparam int FRAME_CYC = (MCLK_PER_XTAL * XTAL_KHZ * FRAME_US) / 1000;
   localparam int PDN_COUNT_MCLK = 250;
   localparam int WAKE_MCLK_CYC = 2;
endpackage : pmc_pkg
`default_nettype wire

// File: core/pmc_clk_div.sv
`default_nettype none
module pmc_clk_div (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic run,
   input wire logic [7:0] ratio,
   output logic tickOut,
   output logic mclkLevel
);
   import pmc_pkg::*;
   logic [7:0] cnt_q, cnt_d;
   logic lvl_q, lvl_d;
   logic [7:0] ratio_q, ratio_d;
   logic tick_d, tick_q;

   // ****************************************
   // glitch free divider: ratio taken at period end
   // ****************************************
   always_comb begin
      cnt_d = cnt_q;
      lvl_d = lvl_q;
      ratio_d = ratio_q;
      tick_d = 1'b0;
      if (!run) begin
         cnt_d = 8'h00;
         lvl_d = 1'b1;
      end else if (ratio_q == 8'h01) begin
         lvl_d = ~lvl_q;
         tick_d = lvl_q;
         ratio_d = ratio;
      end else if (cnt_q == ratio_q - 8'h01) begin
         cnt_d = 8'h00;
         lvl_d = 1'b1;
         tick_d = 1'b1;
         ratio_d = ratio;
      end else begin
         cnt_d = cnt_q + 8'h01;
         if (cnt_q == (ratio_q >> 1) - 8'h01) begin
            lvl_d = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 8'h00;
         lvl_q <= 1'b1;
         ratio_q <= {4'h0, DIV_6M144};
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         lvl_q <= lvl_d;
         ratio_q <= ratio_d;
         tick_q <= tick_d;
      end
   end

   assign tickOut = tick_q;
   assign mclkLevel = lvl_q;
endmodule : pmc_clk_div
`default_nettype wire

// File: core/power_mode_clock_manager.sv
// Functional notes
// - interrupt output active low, changes only at 125 us frame boundaries
// - interrupt stays asserted until cause register read or reset
// - reset abandons all activity and returns logic to reset state
// - release of reset enters Idle mode
// - master clock keeps toggling while reset held
// - read qualified by select and low strobe; data driven after falling edge
// - write qualified by select and low strobe; data captured at rising edge
// - master clock from crystal by programmable divider, seven rates
// - four power modes from mode field, unused blocks disabled
// - key event speeds master clock up without host action
// - voice and data mode enables every block
// - data only mode as voice and data but audio off
// - idle keeps clock, host bus, line interface and hook interrupt
// - idle disables switch, link, audio and port except activation interrupt
// - frame sync and serial clock tristate until switch or master mode
// - each idle entry clears link controller read-only registers
// - power-down stops all clocks, keeps wake detection only
// - power-down refused unless enable bit set
// - count 250 master clocks then stop clock and crystal drive high
// - interrupt during countdown cancels it and clears power-down selection
// - line not deactivated at countdown end keeps oscillator running
// - mode 11 enters power-down if enabled else idle
// - select with write strobe, hook change or wake events exit power-down
// - two master clocks before interrupt after power-down exit
// - reset wake gives 6.144 MHz, others keep programmed rate
`default_nettype none
module power_mode_clock_manager (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic rstIn,
   input wire logic csN,
   input wire logic rdN,
   input wire logic wrN,
   input wire logic [1:0] modeSel,
   input wire logic [2:0] initFreqSel,
   input wire logic [3:0] extFreqSel,
   input wire logic pdnEnable,
   input wire logic speedUpEnable,
   input wire logic speedUpEvent,
   input wire logic intRequest,
   input wire logic intOutDisable,
   input wire logic hookSwitchIn,
   input wire logic hookIntEnable,
   input wire logic wakeEvent,
   input wire logic lineEnable,
   input wire logic lineDeactivated,
   input wire logic lineActivated,
   input wire logic switchConnected,
   input wire logic portIomMaster,
   output logic intN,
   output logic readDataEnable,
   output logic writeCapture,
   output logic masterClkOut,
   output logic crystalDriveOut,
   output logic oscRunning,
   output logic pdnSelClear,
   output logic extFreqClear,
   output logic linkRoClear,
   output logic [2:0] activeMode,
   output logic hostBusEn,
   output logic lineIfEn,
   output logic linkCtrlEn,
   output logic portEn,
   output logic portActReqEn,
   output logic switchEn,
   output logic toneRingerEn,
   output logic audioEn,
   output logic hookIntEn,
   output logic serialPinsOeN
);
   import pmc_pkg::*;
   localparam int FRAME_W = 12;
   localparam logic [FRAME_W-1:0] FRAME_LAST = FRAME_W'(FRAME_CYC - 1);
   localparam logic [7:0] PDN_LAST = 8'(PDN_COUNT_MCLK - 1);
   localparam logic [1:0] WAKE_LAST = 2'(WAKE_MCLK_CYC);

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ACT = 3'h1,
      ST_COUNT = 3'h2,
      ST_OSC = 3'h3,
      ST_DOWN = 3'h4,
      ST_WAKE = 3'h5
   } pmc_state_t;

   // ****************************************
   // input synchronisers, three stages
   // ****************************************
   localparam int NSYNC = 7;
   logic [NSYNC-1:0] rawIn;
   logic [NSYNC-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
   assign rawIn = {rstIn, csN, rdN, wrN, hookSwitchIn, wakeEvent, lineActivated};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_comb begin
            filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
         end
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               s1_q[gi] <= 1'b1;
               s2_q[gi] <= 1'b1;
               s3_q[gi] <= 1'b1;
               filt_q[gi] <= 1'b1;
            end else begin
               s1_q[gi] <= rawIn[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               filt_q[gi] <= filt_d[gi];
            end
         end
      end
   endgenerate
   logic rstS, csS, rdS, wrS, hookS, wakeS, lineActS;
   assign {rstS, csS, rdS, wrS, hookS, wakeS, lineActS} = filt_q;

   // ****************************************
   // divider control
   // ****************************************
   logic clkRun;
   logic [7:0] ratio;
   logic mclkTick, mclkLvl;
   logic freqReset_q, freqReset_d;

   always_comb begin
      ratio = {4'h0, DIV_6M144};
      unique case (initFreqSel)
         3'h1: ratio = {4'h0, DIV_12M288};
         3'h2: ratio = {4'h0, DIV_3M072};
         3'h4: ratio = {4'h0, DIV_4M096};
         default: ratio = {4'h0, DIV_6M144};
      endcase
      if (!freqReset_q && !(speedUpEnable && speedUpEvent)) begin
         unique case (extFreqSel[CPE_FSEL_LSB +: CPE_FSEL_W])
            4'h1: ratio = DIV_1M536;
            4'h2: ratio = DIV_0M768;
            4'h3: ratio = DIV_0M384;
            default: ratio = ratio;
         endcase
      end
   end

   pmc_clk_div u_div (
      .mclk(mclk),
      .arst_n(arst_n),
      .run(clkRun),
      .ratio(ratio),
      .tickOut(mclkTick),
      .mclkLevel(mclkLvl)
   );

   // ****************************************
   // power mode sequencer
   // ****************************************
   pmc_state_t st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic [FRAME_W-1:0] frm_q, frm_d;
   logic intN_q, intN_d, intLatch_q, intLatch_d;
   logic hookPrev_q, hookPrev_d;
   logic rdPrev_q, rdPrev_d, wrPrev_q, wrPrev_d;
   logic pdnClr_q, pdnClr_d, roClr_q, roClr_d, fClr_q, fClr_d;
   logic rdOe_q, rdOe_d, wrCap_q, wrCap_d;
   logic [1:0] effMode;
   logic hostWake, hookWake, readStrobe, frameEdge;

   assign effMode = (modeSel == MODE_PDN && !pdnEnable) ? MODE_IDLE : modeSel;
   assign hostWake = !csS && !wrS;
   assign hookWake = hookIntEnable && (hookS != hookPrev_q);
   assign readStrobe = !csS && rdPrev_q && !rdS;
   assign frameEdge = (frm_q == FRAME_LAST);

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      frm_d = frameEdge ? '0 : frm_q + 1'b1;
      intLatch_d = intLatch_q;
      intN_d = intN_q;
      hookPrev_d = hookS;
      rdPrev_d = rdS;
      wrPrev_d = wrS;
      pdnClr_d = 1'b0;
      roClr_d = 1'b0;
      fClr_d = 1'b0;
      rdOe_d = !csS && !rdS;
      wrCap_d = !csS && !wrPrev_q && wrS && (st_q != ST_DOWN);
      if (intRequest && !intOutDisable && st_q != ST_WAKE) begin
         intLatch_d = 1'b1;
      end else if (readStrobe) begin
         intLatch_d = 1'b0;
      end
      if (frameEdge && clkRun) begin
         intN_d = !intLatch_q;
      end
      unique case (st_q)
         ST_IDLE, ST_ACT: begin
            if (effMode == MODE_PDN) begin
               st_d = ST_COUNT;
               cnt_d = 8'h00;
            end else if (effMode == MODE_IDLE) begin
               st_d = ST_IDLE;
            end else begin
               st_d = ST_ACT;
            end
            if (st_q == ST_ACT && st_d == ST_IDLE) begin
               roClr_d = 1'b1;
            end
         end
         ST_COUNT: begin
            if (!intN_q || effMode != MODE_PDN) begin
               st_d = ST_IDLE;
               pdnClr_d = !intN_q;
               roClr_d = 1'b1;
            end else if (mclkTick) begin
               if (cnt_q == PDN_LAST) begin
                  st_d = (lineEnable && !lineDeactivated) ? ST_OSC : ST_DOWN;
               end else begin
                  cnt_d = cnt_q + 8'h01;
               end
            end
         end
         ST_OSC: begin
            if (lineActS || hostWake || hookWake || wakeS) begin
               st_d = ST_WAKE;
               cnt_d = 8'h00;
            end else if (lineDeactivated) begin
               st_d = ST_DOWN;
            end
         end
         ST_DOWN: begin
            if (hostWake || hookWake || wakeS) begin
               st_d = ST_WAKE;
               cnt_d = 8'h00;
            end
         end
         ST_WAKE: begin
            pdnClr_d = 1'b1;
            if (mclkTick) begin
               if (cnt_q[1:0] == WAKE_LAST - 2'h1) begin
                  st_d = ST_IDLE;
                  roClr_d = 1'b1;
               end else begin
                  cnt_d = cnt_q + 8'h01;
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
      if (st_q != ST_IDLE && st_q != ST_ACT) begin
         intN_d = (st_q == ST_COUNT) ? intN_d : 1'b1;
      end
      if (speedUpEnable && speedUpEvent) begin
         fClr_d = 1'b1;
      end
   end

   assign clkRun = (st_q != ST_OSC) && (st_q != ST_DOWN);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= ST_IDLE;
         cnt_q <= 8'h00;
         frm_q <= '0;
         intN_q <= 1'b1;
         intLatch_q <= 1'b0;
         hookPrev_q <= 1'b1;
         rdPrev_q <= 1'b1;
         wrPrev_q <= 1'b1;
         pdnClr_q <= 1'b0;
         roClr_q <= 1'b0;
         fClr_q <= 1'b0;
         rdOe_q <= 1'b0;
         wrCap_q <= 1'b0;
         freqReset_q <= 1'b1;
      end else if (rstS) begin
         st_q <= ST_IDLE;
         cnt_q <= 8'h00;
         frm_q <= frm_d;
         intN_q <= 1'b1;
         intLatch_q <= 1'b0;
         hookPrev_q <= hookS;
         rdPrev_q <= 1'b1;
         wrPrev_q <= 1'b1;
         pdnClr_q <= 1'b1;
         roClr_q <= 1'b1;
         fClr_q <= 1'b1;
         rdOe_q <= 1'b0;
         wrCap_q <= 1'b0;
         freqReset_q <= 1'b1;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         frm_q <= frm_d;
         intN_q <= intN_d;
         intLatch_q <= intLatch_d;
         hookPrev_q <= hookPrev_d;
         rdPrev_q <= rdPrev_d;
         wrPrev_q <= wrPrev_d;
         pdnClr_q <= pdnClr_d;
         roClr_q <= roClr_d;
         fClr_q <= fClr_d;
         rdOe_q <= rdOe_d;
         wrCap_q <= wrCap_d;
         freqReset_q <= freqReset_q && !wrCap_d;
      end
   end

   // ****************************************
   // block enables and output registers
   // ****************************************
   logic [2:0] modeOut_d, modeOut_q;
   logic [9:0] en_d, en_q;
   logic serOe_q, mclk_q, xd_q, osc_q;
   always_comb begin
      modeOut_d = st_q;
      en_d = '0;
      if (st_q == ST_ACT) begin
         en_d = {8'hFF, 2'h3};
         en_d[0] = (effMode == MODE_AVD);
      end else if (st_q == ST_IDLE || st_q == ST_COUNT || st_q == ST_WAKE) begin
         // host, line, link, port, act-req, switch, ringer, hook, unused, audio
         en_d = {1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      end else begin
         en_d[8] = lineEnable;
         en_d[5] = 1'b1;
         en_d[2] = hookIntEnable;
      end
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         modeOut_q <= 3'h0;
         en_q <= '0;
         serOe_q <= 1'b1;
         mclk_q <= 1'b1;
         xd_q <= 1'b1;
         osc_q <= 1'b1;
      end else begin
         modeOut_q <= modeOut_d;
         en_q <= rstS ? 10'h000 : en_d;
         serOe_q <= rstS ? 1'b1 : (serOe_q && !(switchConnected || portIomMaster));
         mclk_q <= mclkLvl;
         xd_q <= (st_q == ST_DOWN) ? 1'b1 : mclkLvl;
         osc_q <= (st_q != ST_DOWN);
      end
   end

   assign intN = intN_q;
   assign readDataEnable = rdOe_q;
   assign writeCapture = wrCap_q;
   assign masterClkOut = mclk_q;
   assign crystalDriveOut = xd_q;
   assign oscRunning = osc_q;
   assign pdnSelClear = pdnClr_q;
   assign extFreqClear = fClr_q;
   assign linkRoClear = roClr_q;
   assign activeMode = modeOut_q;
   assign {hostBusEn, lineIfEn, linkCtrlEn, portEn, portActReqEn} = en_q[9:5];
   assign {switchEn, toneRingerEn, hookIntEn, audioEn} = {en_q[4], en_q[3], en_q[2], en_q[0]};
   assign serialPinsOeN = serOe_q;

   // ****************************************
   // assertions
   // ****************************************
   AST_INT_FRAME: assert property (@(posedge mclk) disable iff (!arst_n)
      $changed(intN_q) |-> $past(frameEdge) || $past(rstS) || ($past(st_q) != ST_IDLE
      && $past(st_q) != ST_ACT)) else $error("interrupt changed off frame");
   AST_INT_HOLD: assert property (@(posedge mclk) disable iff (!arst_n || rstS)
      intLatch_q && !readStrobe |=> intLatch_q) else $error("interrupt dropped");
   AST_RST_IDLE: assert property (@(posedge mclk) disable iff (!arst_n)
      rstS |=> st_q == ST_IDLE) else $error("reset not idle");
   AST_PDN_REFUSE: assert property (@(posedge mclk) disable iff (!arst_n)
      !pdnEnable && st_q == ST_IDLE |=> st_q != ST_COUNT) else $error("pdn entered");
   AST_CANCEL: assert property (@(posedge mclk) disable iff (!arst_n || rstS)
      st_q == ST_COUNT && !intN_q |=> st_q == ST_IDLE && pdnClr_q)
      else $error("countdown not cancelled");
   AST_DOWN_HIGH: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_q == ST_DOWN) [*3] |-> crystalDriveOut && masterClkOut)
      else $error("clock not high in pdn");
   AST_RUN_RESET: assert property (@(posedge mclk) disable iff (!arst_n)
      rstS |=> clkRun) else $error("clock stopped in reset");
   AST_WRITE: assert property (@(posedge mclk) disable iff (!arst_n)
      wrCap_q |-> $past(wrS) && !$past(wrPrev_q)) else $error("bad write capture");
   COV_PDN: cover property (@(posedge mclk) st_q == ST_DOWN);
   COV_OSC: cover property (@(posedge mclk) st_q == ST_OSC);
   COV_WAKE: cover property (@(posedge mclk) st_q == ST_WAKE ##[1:60] st_q == ST_IDLE);
endmodule : power_mode_clock_manager
`default_nettype wire

// File: tb/pmc_host_model.sv
`default_nettype none
module pmc_host_model (
   input wire logic masterClkOut,
   input wire logic goRead,
   input wire logic goWrite,
   input wire logic wake,
   output logic csN,
   output logic rdN,
   output logic wrN,
   output logic busy,
   output int edgeCount
);
   timeunit 1ns;
   timeprecision 1ps;
   logic csQ;
   logic rdQ;
   logic wrQ;
   int holdCnt;
   initial begin
      csQ = 1'b1;
      rdQ = 1'b1;
      wrQ = 1'b1;
      busy = 1'b0;
      holdCnt = 0;
      edgeCount = 0;
   end
   // strobe held four host clocks, select released one clock after it
   always @(posedge masterClkOut) begin
      edgeCount <= edgeCount + 1;
      if (!busy && (goRead || goWrite)) begin
         busy <= 1'b1;
         csQ <= 1'b0;
         rdQ <= !goRead;
         wrQ <= goRead;
         holdCnt <= 4;
      end else if (busy && holdCnt > 0) begin
         holdCnt <= holdCnt - 1;
         if (holdCnt == 1) begin
            rdQ <= 1'b1;
            wrQ <= 1'b1;
         end
      end else if (busy) begin
         csQ <= 1'b1;
         busy <= 1'b0;
      end
   end
   // wake access needs no clock: select and write low together
   assign csN = csQ & ~wake;
   assign wrN = wrQ & ~wake;
   assign rdN = rdQ;
endmodule : pmc_host_model
`default_nettype wire

// File: tb/tb_power_mode_clock_manager.sv
`default_nettype none
module tb_power_mode_clock_manager import pmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, arst_n, rstIn, goRead, goWrite, wake, pdnEnable, speedUpEnable, speedUpEvent;
   logic intRequest, hookIntEnable, lineEnable, switchConnected, portIomMaster;
   logic [1:0] modeSel;
   logic [2:0] initFreqSel;
   logic [3:0] extFreqSel;
   logic intOutDisable = 1'b0;
   logic hookSwitchIn = 1'b1;
   logic wakeEvent = 1'b0;
   logic lineDeactivated = 1'b1;
   logic lineActivated = 1'b0;
   wire csN, rdN, wrN, hostBusy, intN, readDataEnable, writeCapture, masterClkOut;
   wire crystalDriveOut, oscRunning, pdnSelClear, hostBusEn, lineIfEn, linkCtrlEn, portEn;
   wire switchEn, toneRingerEn, audioEn, hookIntEn, serialPinsOeN;
   wire extFreqClear, linkRoClear, portActReqEn;
   wire [2:0] activeMode;
   wire [7:0] en = {hostBusEn, lineIfEn, linkCtrlEn, portEn, switchEn, toneRingerEn, audioEn,
      hookIntEn};
   int edgeCount, cycleNo, nErrors, nCompared, wcSeen, rdeSeen, tFall, k, c0, roSeen;
   logic wrHighAtCap;
   pmc_mode_t m;

   power_mode_clock_manager DUT (.mclk(mclk), .arst_n(arst_n), .rstIn(rstIn), .csN(csN),
      .rdN(rdN), .wrN(wrN), .modeSel(modeSel), .initFreqSel(initFreqSel),
      .extFreqSel(extFreqSel), .pdnEnable(pdnEnable), .speedUpEnable(speedUpEnable),
      .speedUpEvent(speedUpEvent), .intRequest(intRequest), .intOutDisable(intOutDisable),
      .hookSwitchIn(hookSwitchIn), .hookIntEnable(hookIntEnable), .wakeEvent(wakeEvent),
      .lineEnable(lineEnable), .lineDeactivated(lineDeactivated),
      .lineActivated(lineActivated), .switchConnected(switchConnected),
      .portIomMaster(portIomMaster), .intN(intN), .readDataEnable(readDataEnable),
      .writeCapture(writeCapture), .masterClkOut(masterClkOut),
      .crystalDriveOut(crystalDriveOut), .oscRunning(oscRunning), .pdnSelClear(pdnSelClear),
      .extFreqClear(extFreqClear), .linkRoClear(linkRoClear), .activeMode(activeMode),
      .hostBusEn(hostBusEn), .lineIfEn(lineIfEn), .linkCtrlEn(linkCtrlEn), .portEn(portEn),
      .portActReqEn(portActReqEn),
      .switchEn(switchEn), .toneRingerEn(toneRingerEn), .audioEn(audioEn),
      .hookIntEn(hookIntEn), .serialPinsOeN(serialPinsOeN));
   pmc_host_model host (.masterClkOut(masterClkOut), .goRead(goRead), .goWrite(goWrite),
      .wake(wake), .csN(csN), .rdN(rdN), .wrN(wrN), .busy(hostBusy), .edgeCount(edgeCount));

   // ****************************************
   // clock, monitors and bench helpers
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycleNo++;
      if (writeCapture === 1'b1) begin
         wcSeen++;
         wrHighAtCap &= (wrN === 1'b1);
      end
      if (readDataEnable === 1'b1) rdeSeen++;
      if (linkRoClear === 1'b1) roSeen++;
      if (cycleNo == 60000) begin
         nErrors++;
         summarize();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         nErrors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("compared %0d mismatches %0d", nCompared, nErrors);
      if (nErrors == 0 && nCompared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize
   function automatic logic [7:0] expEn(input pmc_mode_t md);
      case (md)
         MODE_AVD: expEn = 8'hFF;
         MODE_ADO: expEn = 8'hFD;
         default: expEn = 8'hC1;
      endcase
   endfunction : expEn
   function automatic logic [7:0] enMask(input pmc_mode_t md);
      enMask = (md == MODE_IDLE) ? 8'hFB : 8'hFE;
   endfunction : enMask
   task automatic checkEn(input pmc_mode_t md);
      check("enables", 32'(en & enMask(md)), 32'(expEn(md) & enMask(md)));
   endtask : checkEn
   task automatic access(input logic rd);
      if (rd) goRead = 1'b1;
      else goWrite = 1'b1;
      for (k = 0; k < 200 && hostBusy !== 1'b1; k++) cyc(1);
      goRead = 1'b0;
      goWrite = 1'b0;
      for (k = 0; k < 400 && hostBusy !== 1'b0; k++) cyc(1);
      cyc(10);
   endtask : access
   // edges of the master clock over 384 cycles, within one edge of the ratio
   task automatic meas(input int div);
      cyc(128);
      c0 = edgeCount;
      cyc(384);
      check("mclk edges", 32'((edgeCount - c0 >= 384 / div - 1) &&
         (edgeCount - c0 <= 384 / div + 1)), 32'h1);
   endtask : meas

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {arst_n, rstIn, goRead, goWrite, wake, pdnEnable, speedUpEnable, speedUpEvent} = '0;
      {intRequest, lineEnable, switchConnected, portIomMaster, modeSel, initFreqSel} = '0;
      hookIntEnable = 1'b1;
      extFreqSel = 4'h3;
      wrHighAtCap = 1'b1;
      void'($urandom(32'h442C));
      cyc(2);
      arst_n = 1'b1;
      cyc(16);
      check("serial oe", 32'(serialPinsOeN), 32'h1);
      check("int idle", 32'(intN), 32'h1);
      checkEn(MODE_IDLE);
      check("act req", 32'(portActReqEn), 32'h1);
      check("mode out", 32'(activeMode), 32'h0);
      meas(4);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         m = pmc_mode_t'($urandom_range(2));
         modeSel = m;
         cyc(16);
         checkEn(m);
      end
      modeSel = MODE_AVD;
      switchConnected = 1'b1;
      cyc(16);
      check("serial oe", 32'(serialPinsOeN), 32'h0);
      switchConnected = 1'b0;
      $display("test modes done");
      access(1'b0);
      check("write pulses", 32'(wcSeen), 32'h1);
      check("capture after rise", 32'(wrHighAtCap), 32'h1);
      access(1'b1);
      check("read seen", 32'(rdeSeen > 0), 32'h1);
      check("read released", 32'(readDataEnable), 32'h0);
      meas(64);
      initFreqSel = 3'h1;
      extFreqSel = 4'h0;
      meas(2);
      initFreqSel = 3'h0;
      meas(4);
      initFreqSel = 3'h4;
      meas(6);
      initFreqSel = 3'h2;
      meas(8);
      extFreqSel = 4'h1;
      meas(16);
      extFreqSel = 4'h2;
      meas(32);
      extFreqSel = 4'h3;
      speedUpEnable = 1'b1;
      speedUpEvent = 1'b1;
      meas(8);
      check("speed clear", 32'(extFreqClear), 32'h1);
      speedUpEvent = 1'b0;
      speedUpEnable = 1'b0;
      initFreqSel = 3'h0;
      extFreqSel = 4'h0;
      $display("test clock rates done");
      intRequest = 1'b1;
      for (k = 0; k < 3200 && intN !== 1'b0; k++) cyc(1);
      tFall = cycleNo;
      intRequest = 1'b0;
      cyc(3000);
      check("int held", 32'(intN), 32'h0);
      access(1'b1);
      for (k = 0; k < 3200 && intN !== 1'b1; k++) cyc(1);
      check("int cleared", 32'(intN), 32'h1);
      check("frame aligned", 32'((cycleNo - tFall) % FRAME_CYC), 32'h0);
      $display("test interrupt done");
      roSeen = 0;
      modeSel = MODE_PDN;
      cyc(1500);
      meas(4);
      check("ro clear", 32'(roSeen), 32'h1);
      checkEn(MODE_IDLE);
      pdnEnable = 1'b1;
      lineEnable = 1'b1;
      lineDeactivated = 1'b0;
      cyc(1500);
      check("osc kept", 32'(oscRunning), 32'h1);
      lineDeactivated = 1'b1;
      c0 = edgeCount;
      cyc(100);
      check("mclk stopped", 32'(edgeCount - c0), 32'h0);
      check("mclk high", 32'({masterClkOut, crystalDriveOut}), 32'h3);
      check("osc stopped", 32'(oscRunning), 32'h0);
      modeSel = MODE_IDLE;
      wake = 1'b1;
      cyc(20);
      wake = 1'b0;
      meas(4);
      $display("test power down done");
      extFreqSel = 4'h3;
      cyc(64);
      modeSel = MODE_PDN;
      cyc(20);
      intRequest = 1'b1;
      for (k = 0; k < 3400 && pdnSelClear !== 1'b1; k++) cyc(1);
      check("countdown cancel", 32'(pdnSelClear), 32'h1);
      intRequest = 1'b0;
      modeSel = MODE_IDLE;
      meas(64);
      access(1'b1);
      $display("test cancel done");
      modeSel = MODE_AVD;
      cyc(16);
      rstIn = 1'b1;
      modeSel = MODE_IDLE;
      meas(4);
      check("reset enables", 32'(en), 32'h0);
      check("reset int", 32'(intN), 32'h1);
      rstIn = 1'b0;
      cyc(16);
      checkEn(MODE_IDLE);
      check("serial oe", 32'(serialPinsOeN), 32'h1);
      meas(4);
      $display("test mid reset done");
      summarize();
   end
endmodule : tb_power_mode_clock_manager
`default_nettype wire
